// >>> lcc_link_model.sv
// Purpose: link machine stand-in that raises slot counter events
// Assumes: one increment per cycle while cnt_inc is high
// Notes:   idle address lines show the inverse of the last event
`timescale 1ns/100ps
module lcc_link_model
(
    // clock and reset
    input  wire logic       mclk,
    input  wire logic       arst_n,
    // counter event port
    output      logic       cnt_inc,
    output      logic [3:0] cnt_slot,
    output      logic [4:0] cnt_loc
);
    // quiet start, no event pending
    initial
    begin
        cnt_inc = 1'b0;
        cnt_slot = 4'h0;
        cnt_loc = 5'h00;
    end

    // raises n increment events for slot s and location l, then goes idle
    task automatic bump(input logic [3:0] s, input logic [4:0] l, input int n);
        repeat (n)
        begin
            @(posedge mclk);
            cnt_inc <= 1'b1;
            cnt_slot <= s;
            cnt_loc <= l;
        end
        @(posedge mclk);
        cnt_inc <= 1'b0;
        cnt_slot <= ~s; // stale address must not look valid
        cnt_loc <= ~l;
    endtask
endmodule

// >>> lcc_pkg.sv
// Purpose: shared constants for the link control command handler
// Assumes: AHB-Lite register access, 32-bit words
// Notes:   slot memory holds 32 byte locations per slot
package lcc_pkg;
    // register byte offsets
    localparam logic [7:0] OFF_CMD      = 8'h00; // command code byte
    localparam logic [7:0] OFF_SELECT   = 8'h04; // slot select byte
    localparam logic [7:0] OFF_FUNCTION = 8'h08; // function byte, write issues command
    localparam logic [7:0] OFF_STATUS   = 8'h0c; // status
    localparam logic [7:0] OFF_RESP     = 8'h10; // information response, read pops
    localparam logic [7:0] OFF_SWITCH   = 8'h14; // switch address config
    localparam logic [7:0] OFF_POLL     = 8'h18; // polling parameter for select
    localparam logic [7:0] OFF_COUNT    = 8'h1c; // established slot mask, one bit per slot
    // command code and function fields
    localparam logic [2:0] CMD_CONTROL  = 3'h1;
    localparam int         FN_READ_BIT  = 5;
    localparam int         FN_RCLR_BIT  = 6;
    localparam int         FN_WRITE_BIT = 7;
    // read-and-clear legal ranges
    localparam logic [4:0] TSS_ERR_LO   = 5'h07;
    localparam logic [4:0] GSS_ERR_LO   = 5'h0d;
    localparam logic [4:0] ERR_HI       = 5'h0f;
    // sizes
    localparam int         NUM_SLOTS    = 16;
    localparam int         SLOT_BYTES   = 32;
    localparam logic [3:0] RESP_DEPTH   = 4'h8;
    // reset values
    localparam logic [7:0] RST_BYTE     = 8'h00;
    // request key meaning establish tributary
    localparam logic [4:0] KEY_ESTABLISH = 5'h01;
    // command engine states
    typedef enum logic [1:0]
    {
        ST_IDLE  = 2'b00,
        ST_READ0 = 2'b01,
        ST_READ1 = 2'b10,
        ST_CLEAR = 2'b11
    } lcc_state_t;
endpackage

// >>> lcc_resp_queue.sv
// Purpose: internal queue of information responses
// Assumes: push only when not full
// Notes:   16-bit entries, pointer depth fixed
`timescale 1ns/100ps
module lcc_resp_queue
(
    // clock and reset
    input  wire logic        mclk,
    input  wire logic        arst_n,
    // fill side
    input  wire logic        push,
    input  wire logic [15:0] push_data,
    output      logic        full,
    // drain side
    input  wire logic        pop,
    output      logic [15:0] head,
    output      logic        empty
);
    logic [15:0] mem_q [0:7];
    logic [15:0] mem_d [0:7];
    logic [2:0]  wr_q, wr_d, rd_q, rd_d;
    logic [3:0]  cnt_q, cnt_d;
    logic        do_push, do_pop;

    // next pointer and storage
    always_comb
    begin
        do_push = push && !full;
        do_pop  = pop && !empty;
        mem_d   = mem_q;
        wr_d    = wr_q;
        rd_d    = rd_q;
        cnt_d   = cnt_q;
        if (do_push)
        begin
            mem_d[wr_q] = push_data;
            wr_d        = wr_q + 3'h1;
        end
        if (do_pop)
            rd_d = rd_q + 3'h1;
        if (do_push && !do_pop)
            cnt_d = cnt_q + 4'h1;
        else if (do_pop && !do_push)
            cnt_d = cnt_q - 4'h1;
    end

    // register stage
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            for (int i = 0; i < 8; i++)
                mem_q[i] <= 16'h0000;
            wr_q  <= 3'h0;
            rd_q  <= 3'h0;
            cnt_q <= 4'h0;
        end
        else
        begin
            mem_q <= mem_d;
            wr_q  <= wr_d;
            rd_q  <= rd_d;
            cnt_q <= cnt_d;
        end
    end

    assign full  = (cnt_q == lcc_pkg::RESP_DEPTH);
    assign empty = (cnt_q == 4'h0);
    assign head  = mem_q[rd_q];
endmodule

// >>> lcc_top.sv
// Purpose: control command interpreter with status slot storage
// Assumes: host writes command code, select, then function byte to issue
// Notes:   slot 0 is the global slot; results go through a response queue
// Behaviour
// (R01) host establishes each tributary after processor control and mode commands
// (R02) establish command allocates one tributary slot for the address
// (R03) point-to-point hosts establish tributary address one at both ends
// (R04) multi-address tributary gets one establish command per tributary
// (R05) switch address replaces any nonzero address in a command
// (R06) control station keeps a distinct polling parameter per tributary
// (R07) host clears function bits 5 to 7 when sending request key
// (R08) bit 5 reads two consecutive slot bytes without changing them
// (R09) host selects slot by select byte, zero meaning global slot
// (R10) read results are queued and delivered later as information response
// (R11) bit 6 reports location then clears it
// (R12) host aims read-and-clear only at error counter locations
// (R13) read-and-clear outside counter ranges raises procedural error
// (R14) control command recognised by code one in low three bits
//
// The register addresses and the AHB-Lite interface to the registers were left to the implementer.
`timescale 1ns/100ps
module lcc_top
(
    // clock and reset
    input  wire logic        mclk,
    input  wire logic        arst_n,
    // ahb-lite slave
    input  wire logic        hsel,
    input  wire logic [7:0]  haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output      logic        hreadyout,
    output      logic        hresp,
    output      logic [31:0] hrdata,
    // protocol engine counter events
    input  wire logic        cnt_inc,
    input  wire logic [3:0]  cnt_slot,
    input  wire logic [4:0]  cnt_loc,
    // polling parameter to the link machine
    input  wire logic [3:0]  poll_slot,
    output      logic [7:0]  poll_param
);
    logic [7:0]  mem_q [0:lcc_pkg::NUM_SLOTS*lcc_pkg::SLOT_BYTES-1];
    logic [7:0]  poll_q [0:lcc_pkg::NUM_SLOTS-1];
    logic [lcc_pkg::NUM_SLOTS-1:0] alloc_q, alloc_d;
    logic [7:0]  cmd_q, cmd_d, sel_q, sel_d, fn_q, fn_d, sw_q, sw_d;
    logic        perr_q, perr_d, wr_ph_q, rd_ph_q;
    logic [7:0]  addr_q, rdat_d, rdat_q;
    logic [7:0]  lo_q, lo_d;
    logic [8:0]  base_q, base_d;
    lcc_pkg::lcc_state_t st_q, st_d;
    logic        push;
    logic [15:0] push_data, head;
    logic        full, empty, pop;
    logic        acc, wr_fn, wr_poll, clr_en;
    logic [3:0]  slot_eff;
    logic [4:0]  loc;
    logic [8:0]  clr_idx;
    logic [31:0] rd_mux;

    // address phase capture; slave is always ready
    assign acc       = hsel && hready && htrans[1];
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            wr_ph_q <= 1'b0;
            rd_ph_q <= 1'b0;
            addr_q  <= lcc_pkg::RST_BYTE;
        end
        else
        begin
            wr_ph_q <= acc && hwrite;
            rd_ph_q <= acc && !hwrite;
            addr_q  <= acc ? haddr : addr_q;
        end
    end

    // switch value wins over any nonzero address [R05]
    assign slot_eff = (sw_q != 8'h00 && sel_q != 8'h00) ? sw_q[3:0] : sel_q[3:0];
    assign loc      = fn_q[4:0];
    assign wr_fn    = wr_ph_q && (addr_q == lcc_pkg::OFF_FUNCTION);
    assign wr_poll  = wr_ph_q && (addr_q == lcc_pkg::OFF_POLL) && (st_q == lcc_pkg::ST_IDLE);
    assign pop      = rd_ph_q && (addr_q == lcc_pkg::OFF_RESP);
    assign clr_idx  = base_q + 9'(loc);

    // register writes and command engine next state
    always_comb
    begin
        cmd_d   = cmd_q;
        sel_d   = sel_q;
        fn_d    = fn_q;
        sw_d    = sw_q;
        perr_d  = perr_q;
        alloc_d = alloc_q;
        st_d    = st_q;
        lo_d    = lo_q;
        base_d  = base_q;
        push    = 1'b0;
        push_data = 16'h0000;
        clr_en  = 1'b0;
        if (wr_ph_q && st_q == lcc_pkg::ST_IDLE)
        begin
            if (addr_q == lcc_pkg::OFF_CMD)
                cmd_d = hwdata[7:0];
            else if (addr_q == lcc_pkg::OFF_SELECT)
                sel_d = hwdata[7:0];
            else if (addr_q == lcc_pkg::OFF_FUNCTION)
                fn_d = hwdata[7:0];
            else if (addr_q == lcc_pkg::OFF_SWITCH)
                sw_d = hwdata[7:0];
            else if (addr_q == lcc_pkg::OFF_STATUS && hwdata[0])
                perr_d = 1'b0;
        end
        case (st_q)
            lcc_pkg::ST_IDLE:
            begin
                // function write issues the command [R14]
                if (wr_fn && hwdata[2:0] != 3'h0 && cmd_q[2:0] == lcc_pkg::CMD_CONTROL)
                    fn_d = hwdata[7:0];
                if (wr_fn && cmd_q[2:0] == lcc_pkg::CMD_CONTROL) // [R14]
                begin
                    base_d = {slot_eff, 5'h00};
                    if (hwdata[lcc_pkg::FN_RCLR_BIT])
                    begin
                        // legal counter ranges only [R13]
                        if (hwdata[4:0] <= lcc_pkg::ERR_HI &&
                            ((sel_q != 8'h00 && hwdata[4:0] >= lcc_pkg::TSS_ERR_LO) ||
                             (sel_q == 8'h00 && hwdata[4:0] >= lcc_pkg::GSS_ERR_LO)))
                            st_d = lcc_pkg::ST_CLEAR;
                        else
                            perr_d = 1'b1; // [R13]
                    end
                    else if (hwdata[lcc_pkg::FN_READ_BIT])
                        st_d = lcc_pkg::ST_READ0; // [R08]
                    else if (hwdata[7:5] == 3'h0 && hwdata[4:0] == lcc_pkg::KEY_ESTABLISH)
                        alloc_d[slot_eff] = 1'b1; // [R02]
                end
            end
            lcc_pkg::ST_READ0:
            begin
                // base and location only settle at the issuing edge, so fetch here
                lo_d = mem_q[clr_idx]; // [R08]
                st_d = lcc_pkg::ST_READ1;
            end
            lcc_pkg::ST_READ1:
            begin
                // two bytes queued, memory untouched [R08] [R10]
                if (!full)
                begin
                    push      = 1'b1;
                    push_data = {rdat_q, lo_q};
                    st_d      = lcc_pkg::ST_IDLE;
                end
            end
            lcc_pkg::ST_CLEAR:
            begin
                // report then zero the location [R11]
                if (!full)
                begin
                    push      = 1'b1;
                    push_data = {8'h00, mem_q[clr_idx]};
                    clr_en    = 1'b1;
                    st_d      = lcc_pkg::ST_IDLE;
                end
            end
            default: st_d = lcc_pkg::ST_IDLE;
        endcase
    end

    // second byte of a read wraps within the slot
    always_comb
    begin
        rdat_d = (st_q == lcc_pkg::ST_IDLE) ? mem_q[base_q + 9'(loc)]
               : mem_q[base_q + 9'(5'(loc + 5'h01))];
    end

    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            cmd_q   <= lcc_pkg::RST_BYTE;
            sel_q   <= lcc_pkg::RST_BYTE;
            fn_q    <= lcc_pkg::RST_BYTE;
            sw_q    <= lcc_pkg::RST_BYTE;
            perr_q  <= 1'b0;
            alloc_q <= '0;
            st_q    <= lcc_pkg::ST_IDLE;
            lo_q    <= lcc_pkg::RST_BYTE;
            base_q  <= 9'h000;
            rdat_q  <= lcc_pkg::RST_BYTE;
        end
        else
        begin
            cmd_q   <= cmd_d;
            sel_q   <= sel_d;
            fn_q    <= fn_d;
            sw_q    <= sw_d;
            perr_q  <= perr_d;
            alloc_q <= alloc_d;
            st_q    <= st_d;
            lo_q    <= lo_d;
            base_q  <= base_d;
            rdat_q  <= rdat_d;
        end
    end

    // slot memory: counters count only in allocated slots and the global slot 0; clear beats increment
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            for (int i = 0; i < lcc_pkg::NUM_SLOTS*lcc_pkg::SLOT_BYTES; i++)
                mem_q[i] <= lcc_pkg::RST_BYTE;
            for (int j = 0; j < lcc_pkg::NUM_SLOTS; j++)
                poll_q[j] <= lcc_pkg::RST_BYTE;
        end
        else
        begin
            if (cnt_inc && (alloc_q[cnt_slot] || cnt_slot == 4'h0))
                mem_q[{cnt_slot, cnt_loc}] <= mem_q[{cnt_slot, cnt_loc}] + 8'h01;
            if (clr_en)
                mem_q[clr_idx] <= lcc_pkg::RST_BYTE; // [R11]
            if (wr_poll)
                poll_q[slot_eff] <= hwdata[7:0]; // [R06]
        end
    end

    assign poll_param = poll_q[poll_slot]; // [R06]

    // read data mux, unmapped reads zero
    always_comb
    begin
        rd_mux = 32'h0000_0000;
        if (addr_q == lcc_pkg::OFF_CMD)
            rd_mux = {24'h0, cmd_q};
        else if (addr_q == lcc_pkg::OFF_SELECT)
            rd_mux = {24'h0, sel_q};
        else if (addr_q == lcc_pkg::OFF_FUNCTION)
            rd_mux = {24'h0, fn_q};
        else if (addr_q == lcc_pkg::OFF_STATUS)
            rd_mux = {29'h0, (st_q != lcc_pkg::ST_IDLE), !empty, perr_q};
        else if (addr_q == lcc_pkg::OFF_RESP)
            rd_mux = {15'h0, !empty, head};
        else if (addr_q == lcc_pkg::OFF_SWITCH)
            rd_mux = {24'h0, sw_q};
        else if (addr_q == lcc_pkg::OFF_POLL)
            rd_mux = {24'h0, poll_q[slot_eff]};
        else if (addr_q == lcc_pkg::OFF_COUNT)
            rd_mux = {16'h0, alloc_q};
    end
    assign hrdata = rd_mux;

    // response queue [R10]
    lcc_resp_queue u_queue
    (
        .mclk      (mclk),
        .arst_n    (arst_n),
        .push      (push),
        .push_data (push_data),
        .full      (full),
        .pop       (pop),
        .head      (head),
        .empty     (empty)
    );
endmodule

// >>> lcc_top_checker.sv
// Purpose: port-level checks of the command handler
// Assumes: zero-wait slave, no writes while the engine is busy
// Notes:   shadow state compared only once the engine has settled
`timescale 1ns/100ps
module lcc_top_checker
(
    // clock and reset
    input  wire logic        mclk,
    input  wire logic        arst_n,
    // bus
    input  wire logic        hsel,
    input  wire logic [7:0]  haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    input  wire logic        hreadyout,
    input  wire logic        hresp,
    input  wire logic [31:0] hrdata,
    // link side
    input  wire logic        cnt_inc,
    input  wire logic [3:0]  cnt_slot,
    input  wire logic [4:0]  cnt_loc,
    input  wire logic [3:0]  poll_slot,
    input  wire logic [7:0]  poll_param
);
    logic        ap_q, wr_q, pe_q;
    logic [7:0]  ad_q, cmd_q, sel_q, sw_q;
    logic [15:0] mask_q;
    logic [2:0]  quiet_q;
    // data phase decode
    wire dw = ap_q && wr_q;
    wire dr = ap_q && !wr_q;
    wire [3:0] es = (sw_q != 8'h00 && sel_q != 8'h00) ? sw_q[3:0] : sel_q[3:0];
    wire [4:0] lc = hwdata[4:0];
    wire lo = (sel_q != 8'h00) ? (lc < lcc_pkg::TSS_ERR_LO) : (lc < lcc_pkg::GSS_ERR_LO);
    wire bad = lo || lc > lcc_pkg::ERR_HI;
    wire fnw = dw && ad_q == lcc_pkg::OFF_FUNCTION && cmd_q[2:0] == lcc_pkg::CMD_CONTROL;

    // shadow of host-visible state; quiet counter hides engine latency
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            ap_q <= 1'b0;
            wr_q <= 1'b0;
            ad_q <= 8'h00;
            cmd_q <= 8'h00;
            sel_q <= 8'h00;
            sw_q <= 8'h00;
            pe_q <= 1'b0;
            mask_q <= 16'h0000;
            quiet_q <= 3'h7;
        end
        else
        begin
            ap_q <= hsel && hready && htrans[1];
            wr_q <= hwrite;
            ad_q <= haddr;
            if (dw && ad_q == lcc_pkg::OFF_CMD) cmd_q <= hwdata[7:0];
            if (dw && ad_q == lcc_pkg::OFF_SELECT) sel_q <= hwdata[7:0];
            if (dw && ad_q == lcc_pkg::OFF_SWITCH) sw_q <= hwdata[7:0];
            if (fnw && hwdata[6] && bad) pe_q <= 1'b1;
            else if (dw && ad_q == lcc_pkg::OFF_STATUS && hwdata[0]) pe_q <= 1'b0;
            if (fnw && hwdata[7:0] == 8'h01) mask_q[es] <= 1'b1;
            quiet_q <= fnw ? 3'h0 : (quiet_q == 3'h7 ? 3'h7 : quiet_q + 3'h1);
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!arst_n);

    AST_OKAY: assert property (hreadyout && !hresp)
        else $error("bus answer not zero-wait okay");
    AST_POLL_STABLE: assert property (!$past(dw && ad_q == lcc_pkg::OFF_POLL)
        && $stable(poll_slot) |-> $stable(poll_param)) else $error("poll value moved");
    AST_POLL_RESET: assert property ($rose(arst_n) |-> poll_param == 8'h00)
        else $error("poll value not cleared by reset");
    AST_MASK: assert property (dr && ad_q == lcc_pkg::OFF_COUNT && quiet_q == 3'h7
        |-> hrdata == {16'h0000, mask_q}) else $error("slot mask wrong");
    AST_PERR: assert property (dr && ad_q == lcc_pkg::OFF_STATUS && quiet_q == 3'h7
        |-> hrdata[0] == pe_q) else $error("procedural error flag wrong");
    AST_STATUS_UPPER: assert property (dr && ad_q == lcc_pkg::OFF_STATUS
        |-> hrdata[31:3] == 29'h0) else $error("status upper bits set");
    AST_RESP_FORM: assert property (dr && ad_q == lcc_pkg::OFF_RESP
        |-> hrdata[31:17] == 15'h0) else $error("response upper bits set");
    AST_UNMAPPED: assert property (dr && ad_q >= 8'h20 |-> hrdata == 32'h0)
        else $error("unmapped read not zero");

    // main scenarios reached
    cover property (fnw && hwdata[6]);
    cover property (fnw && hwdata[5]);
    cover property (pe_q);
endmodule

bind lcc_top lcc_top_checker u_lcc_top_checker (.mclk(mclk), .arst_n(arst_n),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .cnt_inc(cnt_inc), .cnt_slot(cnt_slot), .cnt_loc(cnt_loc),
    .poll_slot(poll_slot), .poll_param(poll_param));

// >>> test_lcc_top.sv
// Purpose: self-checking bench for the command handler
// Assumes: bench plays the host over the register bus
// Notes:   error cases run last since their response handling is open
`timescale 1ns/100ps
module test_lcc_top;
    logic        mclk = 1'b0;
    logic        arst_n = 1'b0;
    logic        hsel = 1'b0;
    logic [7:0]  haddr = 8'h00;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [2:0]  hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic [3:0]  poll_slot = 4'h0;
    logic        hreadyout, hresp, cnt_inc;
    logic [31:0] hrdata, rd;
    logic [3:0]  cnt_slot;
    logic [4:0]  cnt_loc;
    logic [7:0]  poll_param;
    int          fail_count = 0;
    int          num_checks = 0;
    int          cycles = 0;

    always #10 mclk = ~mclk;

    lcc_top u_lcc_top (.mclk(mclk), .arst_n(arst_n), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .cnt_inc(cnt_inc), .cnt_slot(cnt_slot), .cnt_loc(cnt_loc),
        .poll_slot(poll_slot), .poll_param(poll_param));
    lcc_link_model u_lcc_link_model (.mclk(mclk), .arst_n(arst_n), .cnt_inc(cnt_inc),
        .cnt_slot(cnt_slot), .cnt_loc(cnt_loc));

    task automatic wrap_up;
        if (fail_count == 0 && num_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // a hung handshake must still end in the report
    always @(posedge mclk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            fail_count++;
            wrap_up();
        end
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // single word transfer; read data taken at the data phase end edge
    task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
        @(posedge mclk);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= 2'h2;
        do @(posedge mclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge mclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask

    // command code, select, then function issues; gap lets the engine settle
    task automatic issue(input logic [7:0] c, input logic [7:0] s, input logic [7:0] f);
        bus(lcc_pkg::OFF_CMD, 1'b1, {24'h0, c});
        bus(lcc_pkg::OFF_SELECT, 1'b1, {24'h0, s});
        bus(lcc_pkg::OFF_FUNCTION, 1'b1, {24'h0, f});
        repeat (6) @(posedge mclk);
    endtask

    // wait for a queued response, then pop it into rd
    task automatic pop;
        int i;
        for (i = 0; i < 40; i++)
        begin
            bus(lcc_pkg::OFF_STATUS, 1'b0, 32'h0);
            if (rd[1] === 1'b1) break;
        end
        bus(lcc_pkg::OFF_RESP, 1'b0, 32'h0);
    endtask

    task automatic t_reset;
        bus(lcc_pkg::OFF_STATUS, 1'b0, 32'h0);
        chk(rd, 32'h0);
        bus(lcc_pkg::OFF_COUNT, 1'b0, 32'h0);
        chk(rd, 32'h0);
        bus(8'h20, 1'b0, 32'h0);
        chk(rd, 32'h0);
    endtask

    // point-to-point style: tributary one; wrong code must not allocate
    task automatic t_establish;
        issue(8'h01, 8'h01, 8'h01);
        bus(lcc_pkg::OFF_COUNT, 1'b0, 32'h0);
        chk(rd, 32'h2);
        issue(8'h02, 8'h02, 8'h01);
        bus(lcc_pkg::OFF_COUNT, 1'b0, 32'h0);
        chk(rd, 32'h2);
        issue(8'h01, 8'h04, 8'h01);
        bus(lcc_pkg::OFF_COUNT, 1'b0, 32'h0);
        chk(rd, 32'h12);
    endtask

    // reads twice to show contents survive, then global slot
    task automatic t_read;
        u_lcc_link_model.bump(4'h1, 5'h07, 3);
        u_lcc_link_model.bump(4'h1, 5'h08, 1);
        issue(8'h01, 8'h01, 8'h27);
        pop();
        chk(rd, 32'h00010103);
        issue(8'h01, 8'h01, 8'h27);
        pop();
        chk(rd, 32'h00010103);
        u_lcc_link_model.bump(4'h0, 5'h0d, 2);
        issue(8'h01, 8'h00, 8'h2d);
        pop();
        chk(rd, 32'h00010002);
    endtask

    task automatic t_clear;
        issue(8'h01, 8'h01, 8'h47);
        pop();
        chk(rd, 32'h00010003);
        issue(8'h01, 8'h01, 8'h27);
        pop();
        chk(rd, 32'h00010100);
        issue(8'h01, 8'h00, 8'h4d);
        pop();
        chk(rd, 32'h00010002);
        bus(lcc_pkg::OFF_STATUS, 1'b0, 32'h0);
        chk({31'h0, rd[0]}, 32'h0);
    endtask

    task automatic t_poll;
        bus(lcc_pkg::OFF_SELECT, 1'b1, 32'h1);
        bus(lcc_pkg::OFF_POLL, 1'b1, 32'h5a);
        bus(lcc_pkg::OFF_SELECT, 1'b1, 32'h2);
        bus(lcc_pkg::OFF_POLL, 1'b1, 32'ha5);
        @(posedge mclk);
        poll_slot <= 4'h1;
        repeat (2) @(posedge mclk);
        chk({24'h0, poll_param}, 32'h5a);
        poll_slot <= 4'h2;
        repeat (2) @(posedge mclk);
        chk({24'h0, poll_param}, 32'ha5);
    endtask

    // switch value three overrides select five
    task automatic t_switch;
        bus(lcc_pkg::OFF_SWITCH, 1'b1, 32'h3);
        issue(8'h01, 8'h05, 8'h01);
        bus(lcc_pkg::OFF_COUNT, 1'b0, 32'h0);
        chk(rd, 32'h1a);
        bus(lcc_pkg::OFF_SWITCH, 1'b1, 32'h0);
    endtask

    task automatic perr1(input logic [7:0] s, input logic [7:0] f);
        issue(8'h01, s, f);
        bus(lcc_pkg::OFF_STATUS, 1'b0, 32'h0);
        chk({31'h0, rd[0]}, 32'h1);
        bus(lcc_pkg::OFF_STATUS, 1'b1, 32'h1);
        bus(lcc_pkg::OFF_STATUS, 1'b0, 32'h0);
        chk({31'h0, rd[0]}, 32'h0);
    endtask

    initial
    begin
        repeat (6) @(posedge mclk);
        arst_n <= 1'b1;
        t_reset();
        t_establish();
        t_read();
        t_clear();
        t_poll();
        t_switch();
        perr1(8'h01, 8'h46);
        perr1(8'h00, 8'h4c);
        perr1(8'h01, 8'h50);
        wrap_up();
    end
endmodule
